// File: pkg/sdbc_pkg.sv
// Constants shared by the scaler double-buffer control block
package sdbc_pkg;
   // ==========================================================
   // Data widths and sizes
   localparam int DW          = 32;   // Register word width
   localparam int PIX_W       = 30;   // Pixel word width
   localparam int CNT_W       = 13;   // Pixel counter width
   localparam int COEF_SETS   = 2;    // Programmed coefficient sets
   localparam int COEF_WORDS  = 60;   // Dwords per coefficient set
   localparam int COEF_IDX_W  = 6;    // Index field width

   // ==========================================================
   // Field positions in scaler_control
   localparam int CTRL_ENABLE_BIT   = 31;  // Scaler enable
   localparam int CTRL_ALLOW_DB_BIT = 0;   // Allow double buffer update

   // ==========================================================
   // Reset values
   localparam logic [DW-1:0]         REG_RST   = 32'h0000_0000;
   localparam logic [COEF_IDX_W-1:0] IDX_RST   = 6'h00;
   localparam logic [CNT_W-1:0]      CNT_RST   = 13'h0000;
   localparam logic [PIX_W-1:0]      PIX_RST   = 30'h0000_0000;
endpackage

// File: rtl/sdbc_seam_drop.sv
// Drops post-scaled seam excess pixels at the end of the pipe
`timescale 1ns/1ps
module sdbc_seam_drop
   import sdbc_pkg::*;
(
   input  wire logic             clk,         // Pipe clock
   input  wire logic             rst_n,       // Async reset, low
   input  wire logic             seam_enable, // Seam scaling active
   input  wire logic             seam_right,  // Pipe holds right image
   input  wire logic [CNT_W-1:0] seam_excess, // Post-scale excess
   input  wire logic [CNT_W-1:0] active_width,// Displayed pixels/line
   input  wire logic             in_valid,    // Scaled pixel valid
   input  wire logic             in_sol,      // First pixel of line
   input  wire logic [PIX_W-1:0] in_data,     // Scaled pixel
   output logic                  out_valid,   // Pixel to port valid
   output logic [PIX_W-1:0]      out_data     // Pixel to port
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] pos;
   logic             keep;

   // ==========================================================
   // Position within the line and keep decision
   assign pos  = in_sol ? CNT_RST : cnt_r;
   // Left pipe loses the tail, right pipe loses the head
   assign keep = !seam_enable ||
                 (seam_right ? (pos >= seam_excess)
                             : (pos <  active_width));

   // Pixel counter along the line
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= CNT_RST;
      end else if (in_valid) begin
         cnt_r <= pos + 13'h0001;
      end
   end

   // Registered output stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_data  <= PIX_RST;
      end else begin
         out_valid <= in_valid && keep;
         out_data  <= in_data;
      end
   end
endmodule

// File: rtl/sdbc_top.sv
// Scaler register double buffering and seam pixel dropping
`timescale 1ns/1ps
module sdbc_top
   import sdbc_pkg::*;
(
   input  wire logic                  clk,            // Pipe clock
   input  wire logic                  rst_n,          // Async reset, low
   input  wire logic                  newer_display_generation, // Gen sel
   input  wire logic                  pipe_enable,    // Pipe running
   input  wire logic                  vblank,         // Vertical blank
   input  wire logic                  frame_start,    // Frame start pulse
   input  wire logic [DW-1:0]         wdata,          // Write data
   input  wire logic                  wr_power_gating,// Write strobe
   input  wire logic                  wr_control,     // Write strobe
   input  wire logic                  wr_vphase,      // Write strobe
   input  wire logic                  wr_hphase,      // Write strobe
   input  wire logic                  wr_adaptive,    // Write strobe
   input  wire logic                  wr_winpos,      // Write strobe
   input  wire logic                  wr_winsz,       // Write strobe
   input  wire logic                  coef_set,       // Coefficient set
   input  wire logic                  wr_coef_index,  // Write strobe
   input  wire logic                  wr_coef_data,   // Write strobe
   input  wire logic                  seam_enable,    // Seam scaling on
   input  wire logic                  seam_right,     // Right pipe image
   input  wire logic [CNT_W-1:0]      seam_excess,    // Post excess
   input  wire logic [CNT_W-1:0]      active_width,   // Displayed width
   input  wire logic                  pix_valid,      // Scaled pixel valid
   input  wire logic                  pix_sol,        // Start of line
   input  wire logic [PIX_W-1:0]      pix_data,       // Scaled pixel
   output logic [DW-1:0]              rd_power_gating,// Written value
   output logic [DW-1:0]              rd_control,     // Written value
   output logic [DW-1:0]              rd_vphase,      // Written value
   output logic [DW-1:0]              rd_hphase,      // Written value
   output logic [DW-1:0]              rd_adaptive,    // Written value
   output logic [DW-1:0]              rd_winpos,      // Written value
   output logic [DW-1:0]              rd_winsz,       // Written value
   output logic [COEF_IDX_W-1:0]      rd_coef_index,  // Index of set
   output logic [DW-1:0]              rd_coef_data,   // Word at index
   output logic [DW-1:0]              live_power_gating, // Live value
   output logic [DW-1:0]              live_control,   // Live value
   output logic [DW-1:0]              live_vphase,    // Live value
   output logic [DW-1:0]              live_hphase,    // Live value
   output logic [DW-1:0]              live_adaptive,  // Live value
   output logic [DW-1:0]              live_winpos,    // Live value
   output logic [DW-1:0]              live_winsz,     // Live value
   input  wire logic [COEF_IDX_W-1:0] coef_rd_addr,   // Filter tap lookup
   input  wire logic                  coef_rd_set,    // Filter set lookup
   output logic [DW-1:0]              coef_live_data, // Live coefficient
   output logic                       db_armed,       // Armed status
   output logic                       ctrl_commit,    // Control committed
   output logic                       winsz_commit,   // Size committed
   output logic                       sub_array_power_up, // Start power-up
   output logic                       out_valid,      // Pixel to port
   output logic [PIX_W-1:0]           out_data        // Pixel to port
);

   // ==========================================================
   // Storage
   logic [DW-1:0]         coef_wr_mem [COEF_SETS][COEF_WORDS];
   logic [DW-1:0]         coef_lv_mem [COEF_SETS][COEF_WORDS];
   logic [COEF_IDX_W-1:0] idx_r [COEF_SETS];
   logic                  vblank_r;
   logic                  wr_ctrl_q;
   logic                  wr_winsz_q;
   logic                  armed_r;
   logic                  armed_nxt;

   // Index word cut to the index field width, not limited to one set
   function automatic logic [COEF_IDX_W-1:0] idx_of(
      input logic [DW-1:0] d);
      idx_of = d[COEF_IDX_W-1:0];
   endfunction

   // Index lies inside one coefficient set
   function automatic logic idx_ok(
      input logic [COEF_IDX_W-1:0] i);
      idx_ok = (i < COEF_IDX_W'(COEF_WORDS));
   endfunction

   // ==========================================================
   // Trigger decode
   wire vblank_rise  = vblank && !vblank_r;
   wire allow_db     = rd_control[CTRL_ALLOW_DB_BIT];
   wire new_trig     = pipe_enable && newer_display_generation &&
                       armed_r && vblank_rise && allow_db;
   wire old_ctrl_trig  = pipe_enable && !newer_display_generation &&
                         armed_r && vblank_rise;
   wire old_winsz_trig = pipe_enable && !newer_display_generation &&
                         armed_r && frame_start;
   // Immediate commits one cycle after the write while pipe off
   wire imm_ctrl     = wr_ctrl_q && !pipe_enable;
   wire imm_winsz    = wr_winsz_q && !pipe_enable;
   wire ctrl_go      = imm_ctrl || new_trig || old_ctrl_trig;
   wire winsz_go     = imm_winsz || new_trig || old_winsz_trig;
   wire disarm       = new_trig || old_winsz_trig;
   wire arm          = wr_winsz && pipe_enable;
   // A size write in the disarm cycle keeps the block armed
   assign armed_nxt  = arm ? 1'b1 : (disarm ? 1'b0 : armed_r);
   wire enable_rise  = ctrl_go && rd_control[CTRL_ENABLE_BIT] &&
                       !live_control[CTRL_ENABLE_BIT];

   // Timing edge history, write delays and arming state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vblank_r   <= 1'b0;
         wr_ctrl_q  <= 1'b0;
         wr_winsz_q <= 1'b0;
         armed_r    <= 1'b0;
      end else begin
         vblank_r   <= vblank;
         wr_ctrl_q  <= wr_control;
         wr_winsz_q <= wr_winsz;
         armed_r    <= armed_nxt;
      end
   end

   // ==========================================================
   // First stage: software written values
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_power_gating <= REG_RST;
         rd_control      <= REG_RST;
         rd_vphase       <= REG_RST;
         rd_hphase       <= REG_RST;
         rd_adaptive     <= REG_RST;
         rd_winpos       <= REG_RST;
         rd_winsz        <= REG_RST;
      end else begin
         if (wr_power_gating) rd_power_gating <= wdata;
         if (wr_control)      rd_control      <= wdata;
         if (wr_vphase)       rd_vphase       <= wdata;
         if (wr_hphase)       rd_hphase       <= wdata;
         if (wr_adaptive)     rd_adaptive     <= wdata;
         if (wr_winpos)       rd_winpos       <= wdata;
         if (wr_winsz)        rd_winsz        <= wdata;
      end
   end

   // Coefficient index per set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_r[0] <= IDX_RST;
         idx_r[1] <= IDX_RST;
      end else if (wr_coef_index) begin
         idx_r[coef_set] <= idx_of(wdata);
      end
   end

   // Coefficient first stage, no reset on the array
   always_ff @(posedge clk) begin
      if (wr_coef_data && idx_ok(idx_r[coef_set])) begin
         coef_wr_mem[coef_set][idx_r[coef_set]] <= wdata;
      end
   end

   // Coefficient live copy moves with the control group
   always_ff @(posedge clk) begin
      if (ctrl_go) begin
         coef_lv_mem <= coef_wr_mem;
      end
   end

   // Read ports of the coefficient stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_coef_index  <= IDX_RST;
         rd_coef_data   <= REG_RST;
         coef_live_data <= REG_RST;
      end else begin
         rd_coef_index  <= idx_r[coef_set];
         rd_coef_data   <= idx_ok(idx_r[coef_set]) ?
                           coef_wr_mem[coef_set][idx_r[coef_set]] :
                           REG_RST;
         coef_live_data <= idx_ok(coef_rd_addr) ?
                           coef_lv_mem[coef_rd_set][coef_rd_addr] :
                           REG_RST;
      end
   end

   // ==========================================================
   // Second stage: control group
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live_power_gating <= REG_RST;
         live_control      <= REG_RST;
      end else if (ctrl_go) begin
         live_power_gating <= rd_power_gating;
         live_control      <= rd_control;
      end
   end

   // Second stage: window-size group
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live_vphase   <= REG_RST;
         live_hphase   <= REG_RST;
         live_adaptive <= REG_RST;
         live_winpos   <= REG_RST;
         live_winsz    <= REG_RST;
      end else if (winsz_go) begin
         live_vphase   <= rd_vphase;
         live_hphase   <= rd_hphase;
         live_adaptive <= rd_adaptive;
         live_winpos   <= rd_winpos;
         live_winsz    <= rd_winsz;
      end
   end

   // Status and event pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_commit        <= 1'b0;
         winsz_commit       <= 1'b0;
         sub_array_power_up <= 1'b0;
      end else begin
         ctrl_commit        <= ctrl_go;
         winsz_commit       <= winsz_go;
         sub_array_power_up <= enable_rise;
      end
   end

   assign db_armed = armed_r;

   // ==========================================================
   // Seam excess pixel dropping
   sdbc_seam_drop u_drop (
      .clk          (clk),
      .rst_n        (rst_n),
      .seam_enable  (seam_enable),
      .seam_right   (seam_right),
      .seam_excess  (seam_excess),
      .active_width (active_width),
      .in_valid     (pix_valid),
      .in_sol       (pix_sol),
      .in_data      (pix_data),
      .out_valid    (out_valid),
      .out_data     (out_data)
   );
endmodule

// File: tb/sdbc_top_chk.sv
// Port checker for the scaler double-buffer control block
`timescale 1ns/1ps
module sdbc_top_chk
   import sdbc_pkg::*;
(
   input wire logic             clk,                      // Clock
   input wire logic             rst_n,                    // Reset
   input wire logic             newer_display_generation, // Gen
   input wire logic             pipe_enable,              // Pipe on
   input wire logic             vblank,                   // Blank
   input wire logic             frame_start,              // Frame
   input wire logic [DW-1:0]    wdata,                    // Data
   input wire logic             wr_control,               // Strobe
   input wire logic             wr_winsz,                 // Strobe
   input wire logic             pix_valid,                // Pixel
   input wire logic             seam_enable,              // Seam
   input wire logic [PIX_W-1:0] pix_data,                 // Pixel
   input wire logic [DW-1:0]    rd_control,               // Stage 1
   input wire logic [DW-1:0]    rd_winsz,                 // Stage 1
   input wire logic [DW-1:0]    live_control,             // Stage 2
   input wire logic [DW-1:0]    live_winsz,               // Stage 2
   input wire logic [DW-1:0]    live_vphase,              // Stage 2
   input wire logic             db_armed,                 // Armed
   input wire logic             ctrl_commit,              // Pulse
   input wire logic             winsz_commit,             // Pulse
   input wire logic             sub_array_power_up,       // Pulse
   input wire logic             out_valid,                // Pixel
   input wire logic [PIX_W-1:0] out_data                  // Pixel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Trigger events
   // Vblank rise while armed, pipe running, no competing event
   sequence s_vrise(g, a);
      vblank && !$past(vblank) && pipe_enable && db_armed && !wr_winsz
      && !frame_start && newer_display_generation == g
      && (!g || rd_control[CTRL_ALLOW_DB_BIT] == a);
   endsequence
   // Size write with the pipe held off
   sequence s_off_wr;
      wr_winsz && !pipe_enable ##1 !pipe_enable;
   endsequence
   // ==========================================================
   // Assertions
   a_write_readback: assert property (wr_control |=>
      rd_control == $past(wdata)) else $error("readback wrong");
   a_off_commit: assert property (s_off_wr |-> ##[1:2]
      (winsz_commit && live_winsz == rd_winsz)) else $error("no commit");
   a_size_arms: assert property (wr_winsz && pipe_enable |=>
      db_armed) else $error("not armed");
   a_new_commit: assert property (s_vrise(1, 1) |=> ctrl_commit &&
      winsz_commit && !db_armed && live_winsz == rd_winsz)
      else $error("newer commit wrong");
   a_new_hold: assert property (s_vrise(1, 0) |=> db_armed &&
      !winsz_commit) else $error("commit without allow");
   a_old_ctrl: assert property (s_vrise(0, 0) |=> ctrl_commit &&
      !winsz_commit && db_armed) else $error("older vblank wrong");
   a_old_size: assert property (!newer_display_generation &&
      pipe_enable && db_armed && frame_start && !wr_winsz &&
      !(vblank && !$past(vblank)) |=> winsz_commit && !db_armed &&
      live_winsz == rd_winsz) else $error("older frame wrong");
   a_group_size: assert property (!$stable(live_vphase) |->
      winsz_commit) else $error("phase outside size commit");
   a_power_up: assert property ($rose(live_control[CTRL_ENABLE_BIT])
      |-> sub_array_power_up && ctrl_commit) else $error("no power-up");
   a_seam_pass: assert property (pix_valid && !seam_enable |=>
      out_valid && out_data == $past(pix_data)) else $error("pixel lost");
endmodule

// File: tb/sdbc_top_tb_top.sv
// Testbench for the scaler double-buffer control block
`timescale 1ns/1ps
module sdbc_top_tb_top
   import sdbc_pkg::*;
;
   logic clk, rst_n, newer_display_generation, pipe_enable, vblank;
   logic frame_start, coef_set, seam_enable, seam_right, pix_valid, pix_sol;
   logic coef_rd_set, db_armed, ctrl_commit, winsz_commit, sub_array_power_up;
   logic out_valid, wr_power_gating, wr_control, wr_vphase, wr_hphase;
   logic wr_adaptive, wr_winpos, wr_winsz, wr_coef_index, wr_coef_data;
   logic [DW-1:0] wdata, rd_power_gating, rd_control, rd_vphase, rd_hphase;
   logic [DW-1:0] rd_adaptive, rd_winpos, rd_winsz, rd_coef_data;
   logic [DW-1:0] live_power_gating, live_control, live_vphase, live_hphase;
   logic [DW-1:0] live_adaptive, live_winpos, live_winsz, coef_live_data;
   logic [COEF_IDX_W-1:0] rd_coef_index, coef_rd_addr;
   logic [CNT_W-1:0]      seam_excess, active_width;
   logic [PIX_W-1:0]      pix_data, out_data, ofirst, olast;
   logic [8:0]            ws;
   int                    bad_count = 0, compares = 0, ocnt = 0;
   // Strobe vector fans out to the write ports
   assign {wr_coef_data, wr_coef_index, wr_winsz, wr_winpos, wr_adaptive,
      wr_hphase, wr_vphase, wr_control, wr_power_gating} = ws;
   sdbc_top u_sdbc_top (.clk, .rst_n, .newer_display_generation,
      .pipe_enable, .vblank, .frame_start, .wdata, .wr_power_gating,
      .wr_control, .wr_vphase, .wr_hphase, .wr_adaptive, .wr_winpos,
      .wr_winsz, .coef_set, .wr_coef_index, .wr_coef_data, .seam_enable,
      .seam_right, .seam_excess, .active_width, .pix_valid, .pix_sol,
      .pix_data, .rd_power_gating, .rd_control, .rd_vphase, .rd_hphase,
      .rd_adaptive, .rd_winpos, .rd_winsz, .rd_coef_index, .rd_coef_data,
      .live_power_gating, .live_control, .live_vphase, .live_hphase,
      .live_adaptive, .live_winpos, .live_winsz, .coef_rd_addr,
      .coef_rd_set, .coef_live_data, .db_armed, .ctrl_commit,
      .winsz_commit, .sub_array_power_up, .out_valid, .out_data);
   // Clock of 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Records the pixels passed to the port, cleared at start of line
   always @(posedge clk) begin
      if (pix_valid === 1'b1 && pix_sol === 1'b1) begin
         ocnt <= 0;
      end else if (out_valid === 1'b1) begin
         if (ocnt == 0) ofirst <= out_data;
         olast <= out_data;
         ocnt <= ocnt + 1;
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [DW-1:0] got, exp, input string m);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task automatic wr(input int s, input logic [DW-1:0] v);
      @(posedge clk);
      ws <= 9'h001 << s;
      wdata <= v;
      @(posedge clk);
      ws <= 9'h000;
   endtask
   // One-cycle vblank rise or frame start
   task automatic ev(input bit f);
      @(posedge clk);
      if (f) frame_start <= 1'b1;
      else vblank <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      vblank <= 1'b0;
      step(2);
   endtask
   task automatic line(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         pix_valid <= 1'b1;
         pix_sol <= (i == 0);
         pix_data <= PIX_W'(i + 16);
      end
      @(posedge clk);
      pix_valid <= 1'b0;
      step(2);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_pipe_off();
      wr(2, 32'h0000_0111);
      wr(0, 32'h0000_00A5);
      step(3);
      chk(rd_vphase, 32'h0000_0111, "vphase readback");
      chk(rd_power_gating, 32'h0000_00A5, "gating readback");
      chk(live_vphase, 32'h0000_0000, "vphase early");
      wr(6, 32'h0010_0020);
      step(3);
      chk(live_vphase, 32'h0000_0111, "vphase commit");
      chk(live_power_gating, 32'h0000_0000, "gating held");
      wr(1, 32'h8000_0000);
      step(3);
      chk(live_power_gating, 32'h0000_00A5, "gating commit");
      chk(live_control, 32'h8000_0000, "control commit");
      $display("t_pipe_off done");
   endtask
   task automatic t_newer();
      @(posedge clk);
      pipe_enable <= 1'b1;
      newer_display_generation <= 1'b1;
      wr(3, 32'h0000_0222);
      wr(5, 32'h0000_0444);
      wr(6, 32'h0010_0030);
      step(1);
      chk(db_armed, 32'h1, "not armed");
      chk(rd_hphase, 32'h0000_0222, "hphase readback");
      ev(0);
      chk(live_hphase, 32'h0000_0000, "commit without allow");
      wr(1, 32'h8000_0001);
      step(2);
      chk(live_control, 32'h8000_0000, "control early");
      ev(0);
      chk(live_hphase, 32'h0000_0222, "hphase commit");
      chk(live_control, 32'h8000_0001, "control late");
      chk(live_winpos, 32'h0000_0444, "winpos commit");
      chk(db_armed, 32'h0, "still armed");
      $display("t_newer done");
   endtask
   task automatic t_older();
      @(posedge clk);
      newer_display_generation <= 1'b0;
      coef_rd_addr <= 6'h05;
      wr(7, 32'h0000_0005);
      wr(8, 32'h1234_5678);
      @(posedge clk);
      coef_set <= 1'b1;
      wr(7, 32'h0000_0005);
      wr(8, 32'h0000_9ABC);
      wr(0, 32'h0000_005A);
      wr(4, 32'h0000_0333);
      wr(6, 32'h0010_0040);
      step(2);
      chk(rd_coef_data, 32'h0000_9ABC, "coef set1 readback");
      chk(rd_coef_index, 32'h5, "index readback");
      chk(rd_adaptive, 32'h0000_0333, "adaptive readback");
      @(posedge clk);
      coef_set <= 1'b0;
      step(2);
      chk(rd_coef_data, 32'h1234_5678, "coef readback");
      ev(0);
      chk(live_power_gating, 32'h0000_005A, "gating vblank");
      chk(coef_live_data, 32'h1234_5678, "coef vblank");
      @(posedge clk);
      coef_rd_set <= 1'b1;
      step(2);
      chk(coef_live_data, 32'h0000_9ABC, "coef set1 vblank");
      chk(live_adaptive, 32'h0000_0000, "adaptive early");
      ev(1);
      chk(live_adaptive, 32'h0000_0333, "adaptive frame");
      chk(db_armed, 32'h0, "still armed");
      $display("t_older done");
   endtask
   task automatic t_seam();
      @(posedge clk);
      seam_enable <= 1'b1;
      active_width <= 13'h0003;
      seam_excess <= 13'h0002;
      line(5);
      chk(ocnt, 32'h3, "left count");
      chk(olast, 32'h12, "left last");
      @(posedge clk);
      seam_right <= 1'b1;
      line(5);
      chk(ocnt, 32'h3, "right count");
      chk(ofirst, 32'h12, "right first");
      @(posedge clk);
      seam_enable <= 1'b0;
      line(5);
      chk(ocnt, 32'h5, "pass count");
      $display("t_seam done");
   endtask
   // Main sequence
   initial begin
      {rst_n, newer_display_generation, pipe_enable, vblank} = '0;
      {frame_start, coef_set, seam_enable, seam_right, pix_valid} = '0;
      {pix_sol, coef_rd_set, wdata, ws, coef_rd_addr, seam_excess} = '0;
      {active_width, pix_data} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_pipe_off();
      t_newer();
      t_older();
      t_seam();
      finish_test();
   end
   // Watchdog well beyond the hundred or so cycles expected
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      finish_test();
   end
endmodule
bind sdbc_top sdbc_top_chk u_sdbc_top_chk (.clk, .rst_n,
   .newer_display_generation, .pipe_enable, .vblank, .frame_start, .wdata,
   .wr_control, .wr_winsz, .pix_valid, .seam_enable, .pix_data, .rd_control,
   .rd_winsz, .live_control, .live_winsz, .live_vphase, .db_armed,
   .ctrl_commit, .winsz_commit, .sub_array_power_up, .out_valid, .out_data);
